/* bench/pmu_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Core stand-in: runs, retires, halts late
// ----------------------------------------
module pmu_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Run control and core status
  input wire logic go,
  input wire logic halt_req,
  output logic cpu_run,
  output logic insn_retire
);
  logic go_q;
  logic [1:0] left_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
      cpu_run <= 1'b0;
      left_reg <= 2'h2;
    end else begin
      go_q <= go;
      if (go && !go_q) begin
        cpu_run <= 1'b1;
        left_reg <= 2'h2;
      end else if (!go) begin
        cpu_run <= 1'b0;
      end else if (cpu_run && halt_req && insn_retire) begin
        if (left_reg == 2'h0) begin
          cpu_run <= 1'b0;
        end else begin
          left_reg <= left_reg - 2'h1;
        end
      end
    end
  end

  // Retire every other cycle so halt lags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      insn_retire <= 1'b0;
    end else begin
      insn_retire <= cpu_run && !insn_retire;
    end
  end
endmodule

/* bench/pmu_tb.sv */
`timescale 1ns/1ps
`include "pmu_cfg.svh"
module tb;
  import pmu_pkg::*;
  localparam logic [11:0] C0 = `PMU_OFS_CNT0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] evt = 32'h0;
  logic [3:0] hits = 4'h0;
  logic go = 1'b0;
  logic multi = 1'b0;
  logic slot = 1'b0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, halt_req, brk2_en, win_open, cpu_run, retire, e;
  int errors = 0;
  int checks = 0;

  always #2 clk = ~clk;

  // Narrow counters so overflow is reachable in a short run
  pmu_unit #(.CW(8), .HAS_DSP(1'b0), .HAS_XY(1'b0)) dut_u (
    .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EVT(evt), .CPU_RUN(cpu_run),
    .BRK1_HIT(hits[0]), .BRK2_HIT(hits[1]), .BRK_OTHER_HIT(hits[2]),
    .BRK_IN_SLOT(slot), .INSN_RETIRE(retire), .MULTI_STEP(multi),
    .SWBP_EXEC(hits[3]), .HALT_REQ(halt_req), .BRK2_ENABLED(brk2_en),
    .WIN_OPEN(win_open));

  pmu_cpu_model cpu_u (.clk(clk), .rst_n(rst_n), .go(go),
    .halt_req(halt_req), .cpu_run(cpu_run), .insn_retire(retire));

  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic summarize();
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic ev(input logic [31:0] b, input int n);
    repeat (n) begin
      @(posedge clk);
      evt <= b;
    end
    @(posedge clk);
    evt <= 32'h0;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    hits <= m;
    @(posedge clk);
    hits <= 4'h0;
  endtask

  function automatic logic sig(input int w);
    return (w == 0) ? win_open : (w == 1) ? halt_req : cpu_run;
  endfunction

  // Window 0, halt 1, run 2
  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    while (sig(w) !== v && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) begin
      errors++;
      summarize();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`PMU_OFS_CTRL, `PMU_CTRL_RST, "ctrl");
    rd(`PMU_OFS_BRK, `PMU_BRK_RST, "brk");
    rd(`PMU_OFS_SEL, 32'h0, "sel");
    rd(C0, 32'h0, "cnt0");
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    wr(`PMU_OFS_SEL, {8'(PMU_EV_DSP), 8'(PMU_EV_INSN),
                      8'(PMU_EV_BRANCH), 8'(PMU_EV_TIME)});
    wr(`PMU_OFS_CTRL, 32'(PMU_RUN_TO_BREAK));
    go <= 1'b1;
    wait_for(0, 1'b1);
    ev(32'h38, 5);
    pulse(4'h4);
    wait_for(1, 1'b1);
    wait_for(0, 1'b0);
    wait_for(2, 1'b0);
    wait_for(1, 1'b0);
    go <= 1'b0;
    rd(C0 + 12'h004, 32'd10, "branch");
    rd(C0 + 12'h008, 32'd5, "insn");
    rd(C0 + 12'h00c, 32'd0, "dsp absent");
    apb(1'b0, C0, 32'h0);
    chk("time counted", 32'h1, 32'(q != 32'h0));
    for (int m = 1; m <= 2; m++) begin
      wr(`PMU_OFS_CTRL, 32'h10);
      rd(C0 + 12'h008, 32'h0, "init clear");
      wr(`PMU_OFS_CTRL, 32'(m));
      go <= 1'b1;
      ev(32'h10, 3);
      pulse((m == 1) ? 4'h1 : 4'h2);
      ev(32'h10, 4);
      pulse((m == 1) ? 4'h2 : 4'h1);
      ev(32'h10, 3);
      chk("no halt", 32'h0, 32'(halt_req));
      rd(`PMU_OFS_STAT, 32'h0, "window shut");
      go <= 1'b0;
      rd(C0 + 12'h008, 32'd4, "range insn");
    end
    wr(`PMU_OFS_BRK, 32'h7);
    wr(`PMU_OFS_CTRL, 32'(PMU_RANGE_1_TO_2));
    multi <= 1'b1;
    go <= 1'b1;
    repeat (3) @(posedge clk);
    pulse(4'h1);
    repeat (3) @(posedge clk);
    chk("qualified", 32'h0, 32'(win_open));
    multi <= 1'b0;
    go <= 1'b0;
    wr(`PMU_OFS_BRK, 32'h3);
    repeat (2) @(posedge clk);
    chk("brk2 pin on", 32'h1, 32'(brk2_en));
    pulse(4'h8);
    rd(`PMU_OFS_BRK, 32'h1, "brk2 off");
    chk("brk2 pin off", 32'h0, 32'(brk2_en));
    wr(`PMU_OFS_CTRL, 32'(PMU_RUN_TO_BREAK));
    go <= 1'b1;
    repeat (300) @(posedge clk);
    slot <= 1'b1;
    pulse(4'h4);
    slot <= 1'b0;
    repeat (2) @(posedge clk);
    chk("slot halt late", 32'h0, 32'(halt_req));
    wait_for(1, 1'b1);
    wait_for(2, 1'b0);
    go <= 1'b0;
    rd(`PMU_OFS_STAT, 32'h100, "ovf flag");
    wr(`PMU_OFS_CTRL, 32'h10);
    rd(`PMU_OFS_STAT, 32'h0, "ovf cleared");
    for (int i = 0; i < 4; i++) begin
      rd(C0 + 12'(4 * i), 32'h0, "cnt cleared");
    end
    summarize();
  end
endmodule

/* design/pmu_cfg.svh */
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PMU_OFS_CTRL 12'h000
`define PMU_OFS_STAT 12'h004
`define PMU_OFS_SEL 12'h008
`define PMU_OFS_BRK 12'h00c
`define PMU_OFS_CNT0 12'h010

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PMU_CTRL_MODE_LSB 0
`define PMU_CTRL_INIT_BIT 4
`define PMU_STAT_WIN_BIT 0
`define PMU_STAT_OVF_LSB 8
`define PMU_BRK_EN1_BIT 0
`define PMU_BRK_EN2_BIT 1
`define PMU_BRK_QUAL_BIT 2
`define PMU_SEL_FIELD_W 8
`define PMU_BRK_RST 32'h0000_0003
`define PMU_CTRL_RST 32'h0000_0000

// ----------------------------------------
// Counting constants
// ----------------------------------------
`define PMU_BRANCH_STEP 2

`endif

/* design/pmu_pkg.sv */
package pmu_pkg;

  // Window source selection
  typedef enum logic [1:0] {
    PMU_RUN_TO_BREAK,
    PMU_RANGE_1_TO_2,
    PMU_RANGE_2_TO_1,
    PMU_MODE_SPARE
  } pmu_mode_type;

  // Event source codes, one bit of the event bus each, except PMU_EV_TIME (every cycle) and PMU_EV_OFF (never)
  typedef enum logic [4:0] {
    PMU_EV_OFF, PMU_EV_TIME, PMU_EV_STATES, PMU_EV_BRANCH,
    PMU_EV_INSN, PMU_EV_DSP, PMU_EV_MEM_CONFL, PMU_EV_OTH_CONFL,
    PMU_EV_EXCEPT, PMU_EV_DTLB, PMU_EV_ITLB, PMU_EV_IRQ,
    PMU_EV_BLOCK, PMU_EV_PRIV, PMU_EV_IC_MISS, PMU_EV_DC_MISS,
    PMU_EV_IF_STALL, PMU_EV_DA_STALL, PMU_EV_ICM_STALL, PMU_EV_DCM_STALL,
    PMU_EV_CA_STALL, PMU_EV_XY_STALL, PMU_EV_U_STALL, PMU_EV_MA_STALL,
    PMU_EV_NMA, PMU_EV_NC_CYC, PMU_EV_NC_INSN, PMU_EV_NC_DATA,
    PMU_EV_C_INSN, PMU_EV_C_DATA, PMU_EV_NC_CNT, PMU_EV_C_CNT
  } pmu_event_type;

  typedef enum logic [1:0] {
    PMU_HALT_IDLE,
    PMU_HALT_SLOT,
    PMU_HALT_REQ
  } pmu_halt_type;

endpackage

/* design/pmu_unit.sv */
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// RL1: Run-to-break mode opens window at program start, closes on any break.
// RL2: Range 1-to-2: condition 1 starts counting, condition 2 stops it.
// RL3: Range 2-to-1: condition 2 starts counting, condition 1 stops it.
// RL4: Conditions used as range points never halt the program.
// RL5: Four independent channels count together inside one window.
// RL6: Each channel selects one event source from the full source list.
// RL7: Events of absent optional hardware never count.
// RL8: Halt may lag the match by more than one instruction.
// RL9: Address break on delay slot halts before the branch target.
// RL10: Executing a software breakpoint disables break condition 2.
// RL11: Host overrides condition 2 settings while it is stepping.
// RL12: Host does not step while a range mode is active.
// RL13: Host enables a channel before selecting a range mode.
// RL14: Counts may be off by a few events around window edges.
// RL15: Count-qualified break ignores matches on multi-step instructions.
// RL16: Host programs start and end conditions before running the program.
// RL17: Counters are 32 bits; overflow is visible apart from the count.
// RL18: Counters run on the CPU clock, pausing when it stops.
// RL19: A taken branch advances a branch counter by two.
// RL20: Initialize clears all counters whatever the mode.
// RL21: Sticky overflow flag per channel, cleared by initialize.
`include "pmu_cfg.svh"

module pmu_unit #(
  parameter int NCH = 4,
  parameter int CW = 32,
  parameter bit HAS_DSP = 1'b1,
  parameter bit HAS_MMU = 1'b1,
  parameter bit HAS_XY = 1'b1,
  parameter bit HAS_U = 1'b1
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // CPU events and break matches, CPU clock domain
  input wire logic [31:0] EVT,
  input wire logic CPU_RUN,
  input wire logic BRK1_HIT,
  input wire logic BRK2_HIT,
  input wire logic BRK_OTHER_HIT,
  input wire logic BRK_IN_SLOT,
  input wire logic INSN_RETIRE,
  input wire logic MULTI_STEP,
  input wire logic SWBP_EXEC,
  // Status to the core
  output logic HALT_REQ,
  output logic BRK2_ENABLED,
  output logic WIN_OPEN
);
  import pmu_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [1:0] mode_reg;
  logic [31:0] brk_reg;
  logic [NCH*`PMU_SEL_FIELD_W-1:0] sel_reg;
  logic [CW-1:0] cnt_reg [NCH];
  logic [NCH-1:0] ovf_reg;
  logic win_reg;
  logic init_pulse;
  logic acc;
  logic wr;
  logic hit_map;
  logic [31:0] rd_next;
  pmu_mode_type mode;

  assign acc = PSEL & PENABLE & ~PREADY;
  assign wr = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign mode = pmu_mode_type'(mode_reg);
  assign init_pulse = wr && PADDR == `PMU_OFS_CTRL &&
                      PWDATA[`PMU_CTRL_INIT_BIT];

  always_comb begin
    hit_map = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (PADDR)
      `PMU_OFS_CTRL: rd_next[1:0] = mode_reg;
      `PMU_OFS_STAT: begin
        rd_next[`PMU_STAT_WIN_BIT] = win_reg;
        rd_next[`PMU_STAT_OVF_LSB +: NCH] = ovf_reg;
      end
      `PMU_OFS_SEL: rd_next[NCH*`PMU_SEL_FIELD_W-1:0] = sel_reg;
      `PMU_OFS_BRK: rd_next = brk_reg;
      default: begin
        hit_map = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (PADDR == 12'(`PMU_OFS_CNT0 + 4 * i)) begin
            hit_map = 1'b1;
            rd_next[CW-1:0] = cnt_reg[i];
          end
        end
      end
    endcase
  end

  // One wait state: answer on the second access cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= acc;
      PSLVERR <= acc & ~hit_map;
      if (acc && !PWRITE) begin
        PRDATA <= hit_map ? rd_next : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg <= 2'(`PMU_CTRL_RST);
      sel_reg <= '0;
    end else if (wr) begin
      if (PADDR == `PMU_OFS_CTRL) begin
        mode_reg <= PWDATA[`PMU_CTRL_MODE_LSB +: 2];
      end
      if (PADDR == `PMU_OFS_SEL) begin
        sel_reg <= PWDATA[NCH*`PMU_SEL_FIELD_W-1:0];
      end
    end
  end

  // RL10: software breakpoint wins over the write
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brk_reg <= `PMU_BRK_RST;
    end else begin
      if (wr && PADDR == `PMU_OFS_BRK) begin
        brk_reg <= PWDATA;
      end
      if (SWBP_EXEC) begin
        brk_reg[`PMU_BRK_EN2_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Break qualification
  // ----------------------------------------
  logic c1;
  logic c2;
  logic range_mode;
  logic start_hit;
  logic stop_hit;
  logic halt_cause;

  // RL15: qualified breaks skip multi-step instructions
  assign c1 = BRK1_HIT & brk_reg[`PMU_BRK_EN1_BIT] &
              ~(brk_reg[`PMU_BRK_QUAL_BIT] & MULTI_STEP);
  assign c2 = BRK2_HIT & brk_reg[`PMU_BRK_EN2_BIT] &
              ~(brk_reg[`PMU_BRK_QUAL_BIT] & MULTI_STEP);
  assign range_mode = mode == PMU_RANGE_1_TO_2 || mode == PMU_RANGE_2_TO_1;
  // RL2 RL3: pick start and end points by mode
  assign start_hit = mode == PMU_RANGE_1_TO_2 ? c1 : c2;
  assign stop_hit = mode == PMU_RANGE_1_TO_2 ? c2 : c1;
  // RL4: range points are not halt causes
  assign halt_cause = BRK_OTHER_HIT | (~range_mode & (c1 | c2));

  // ----------------------------------------
  // Halt request sequencing
  // ----------------------------------------
  pmu_halt_type halt_st;

  // RL8 RL9: registered request; slot match waits one retire
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      halt_st <= PMU_HALT_IDLE;
    end else begin
      unique case (halt_st)
        PMU_HALT_IDLE: begin
          if (halt_cause) begin
            halt_st <= BRK_IN_SLOT ? PMU_HALT_SLOT : PMU_HALT_REQ;
          end
        end
        PMU_HALT_SLOT: begin
          if (INSN_RETIRE) begin
            halt_st <= PMU_HALT_REQ;
          end
        end
        PMU_HALT_REQ: begin
          if (!CPU_RUN) begin
            halt_st <= PMU_HALT_IDLE;
          end
        end
        default: halt_st <= PMU_HALT_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HALT_REQ <= 1'b0;
      BRK2_ENABLED <= 1'b0;
      WIN_OPEN <= 1'b0;
    end else begin
      HALT_REQ <= halt_st == PMU_HALT_REQ;
      BRK2_ENABLED <= brk_reg[`PMU_BRK_EN2_BIT];
      WIN_OPEN <= win_reg;
    end
  end

  // ----------------------------------------
  // Measurement window
  // ----------------------------------------
  logic run_q;
  logic win_next;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_q <= 1'b0;
    end else begin
      run_q <= CPU_RUN;
    end
  end

  always_comb begin
    win_next = win_reg;
    if (range_mode) begin
      if (stop_hit) begin
        win_next = 1'b0;
      end else if (start_hit && CPU_RUN) begin
        win_next = 1'b1;
      end
    end else if (halt_cause || !CPU_RUN) begin
      // RL1: any break or stop ends the window
      win_next = 1'b0;
    end else if (CPU_RUN && !run_q) begin
      win_next = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      win_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
    end
  end

  // ----------------------------------------
  // Counter channels
  // ----------------------------------------
  logic [31:0] present;

  // RL7: mask sources of absent hardware
  always_comb begin
    present = 32'hffff_fffe;
    present[PMU_EV_DSP] = HAS_DSP;
    present[PMU_EV_DTLB] = HAS_MMU;
    present[PMU_EV_ITLB] = HAS_MMU;
    present[PMU_EV_XY_STALL] = HAS_XY;
    present[PMU_EV_U_STALL] = HAS_U;
  end

  // RL5: channels are independent copies
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [4:0] src;
    logic ev;
    logic [CW-1:0] step;
    logic [CW:0] sum;

    assign src = sel_reg[g*`PMU_SEL_FIELD_W +: 5];
    // RL6: elapsed time counts every cycle; others follow the bus
    assign ev = present[src] &
                (src == PMU_EV_TIME ? 1'b1 : EVT[src]);
    // RL19: a branch is worth two counts
    assign step = src == PMU_EV_BRANCH ? CW'(`PMU_BRANCH_STEP) : CW'(1);
    assign sum = {1'b0, cnt_reg[g]} + {1'b0, step};

    // RL14: registered window lets closing-cycle events count
    // RL18 RL20: CPU clock only; initialize clears in any mode
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        cnt_reg[g] <= '0;
      end else if (init_pulse) begin
        cnt_reg[g] <= '0;
      end else if (win_reg && ev) begin
        cnt_reg[g] <= sum[CW-1:0];
      end
    end

    // RL17 RL21: sticky wrap flag; initialize zeroes, so no wrap then
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        ovf_reg[g] <= 1'b0;
      end else begin
        ovf_reg[g] <= (ovf_reg[g] & ~init_pulse) |
                      (win_reg & ev & sum[CW] & ~init_pulse);
      end
    end

    a_cnt_frozen: assert property ( // RL1
      @(posedge CORE_CLK) disable iff (!RST_N)
      !win_reg && !init_pulse |=> $stable(cnt_reg[g]))
      else $error("counter moved outside window");

    a_branch_two: assert property ( // RL19
      @(posedge CORE_CLK) disable iff (!RST_N)
      win_reg && !init_pulse && src == PMU_EV_BRANCH && EVT[src] &&
      !sum[CW] |=> cnt_reg[g] == $past(cnt_reg[g]) + CW'(2))
      else $error("branch step not two");

    a_ovf_sticky: assert property ( // RL21
      @(posedge CORE_CLK) disable iff (!RST_N)
      ovf_reg[g] && !init_pulse |=> ovf_reg[g])
      else $error("overflow flag dropped");

    a_absent_hw: assert property ( // RL7
      @(posedge CORE_CLK) disable iff (!RST_N)
      !HAS_DSP && src == PMU_EV_DSP && !init_pulse
      |=> $stable(cnt_reg[g]))
      else $error("absent source counted");
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_init_clears: assert property ( // RL20
    @(posedge CORE_CLK) disable iff (!RST_N)
    init_pulse |=> cnt_reg[0] == '0 && ovf_reg == '0)
    else $error("initialize left counts");

  a_range_start: assert property ( // RL2
    @(posedge CORE_CLK) disable iff (!RST_N)
    mode == PMU_RANGE_1_TO_2 && c1 && !c2 && CPU_RUN |=> win_reg)
    else $error("range 1-2 did not open");

  a_range_rev: assert property ( // RL3
    @(posedge CORE_CLK) disable iff (!RST_N)
    mode == PMU_RANGE_2_TO_1 && c1 |=> !win_reg)
    else $error("range 2-1 did not close");

  a_no_halt_rng: assert property ( // RL4
    @(posedge CORE_CLK) disable iff (!RST_N)
    range_mode && !BRK_OTHER_HIT && halt_st == PMU_HALT_IDLE
    |=> halt_st == PMU_HALT_IDLE)
    else $error("range point halted");

  a_slot_defer: assert property ( // RL9
    @(posedge CORE_CLK) disable iff (!RST_N)
    halt_st == PMU_HALT_IDLE && halt_cause && BRK_IN_SLOT
    |=> !HALT_REQ ##1 !HALT_REQ)
    else $error("halted before slot");

  a_swbp_brk2: assert property ( // RL10
    @(posedge CORE_CLK) disable iff (!RST_N)
    SWBP_EXEC |=> !brk_reg[`PMU_BRK_EN2_BIT] ##1 !BRK2_ENABLED)
    else $error("condition 2 still enabled");

  a_qual_multi: assert property ( // RL15
    @(posedge CORE_CLK) disable iff (!RST_N)
    brk_reg[`PMU_BRK_QUAL_BIT] && MULTI_STEP |-> !c1 && !c2)
    else $error("qualified break on multi-step");

  a_run_opens: assert property ( // RL1
    @(posedge CORE_CLK) disable iff (!RST_N)
    mode == PMU_RUN_TO_BREAK && CPU_RUN && !run_q && !halt_cause
    |=> win_reg ##1 WIN_OPEN)
    else $error("run did not open window");

  a_apb_wait: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY)
    else $error("apb answer not one wait");

endmodule
